/* rtl/acs_pkg.sv */
// Package with constants for the converter command and conversion sequencer
package acs_pkg;
   localparam int          ACS_CONV_CYCLES   = 24;
   localparam int          ACS_CAL_CYCLES    = 300;
   localparam int          ACS_SAMPLE_FIRST  = 3;
   localparam int          ACS_SAMPLE_LAST   = 10;
   localparam int          ACS_CMD_W         = 6;
   localparam int          ACS_RES_W         = 13;
   localparam int          ACS_BUS_W         = 16;
   localparam int          ACS_CNT_W         = 9;
   // Command field positions in the six command bits (bus bits 5..0)
   localparam int          ACS_CMD_SEL_BIT   = 5;
   localparam int          ACS_CMD_Q_BIT     = 4;
   localparam int          ACS_CMD_LSB_BIT   = 0;
   localparam logic [15:0] ACS_BUS_IDLE      = 16'h0000;

   typedef enum logic [1:0]
   {
      ACS_IDLE = 2'b00,
      ACS_CONV = 2'b01,
      ACS_CAL  = 2'b10
   } acs_state_t;
endpackage

/* rtl/acs_sequencer.sv */
// Command decode, conversion and calibration sequencing, done flag and bus read-out
`timescale 1ns/1ps
//
// Overview of operation
// - conversion ends at the end of clock cycle twenty-four of its period.
// - analog input is sampled only during conversion cycles three through ten.
// - active-low done flag falls when conversion completes; result then readable.
// - a new conversion command is accepted immediately after completion.
// - six-bit command on low bus bits latched on chip select or write rising.
// - no calibration at power-up; only on command.
// - conversion may start after first clock; accuracy needs prior calibration.
// - unipolar mode always outputs the sign bit as zero.
// - bipolar mode sets the sign bit from the input polarity.
// - result is thirteen-bit right-justified two's complement, sign extended.
// - done and read falling in one cycle keeps done low until write goes low.
// - calibration takes three hundred cycles; conversion takes twenty-four cycles.
// - conversion command during conversion aborts it and restarts the period.
// - done clears on first chip select with read, or chip select with write.
// - from two cycles after chip select and read go low until two cycles after either rises, all result bits drive the bus.
module acs_sequencer
   import acs_pkg::*;
#(
   parameter int CONV_CYCLES = ACS_CONV_CYCLES,
   parameter int CAL_CYCLES  = ACS_CAL_CYCLES
)
(
   input  wire logic                 core_clk_i,
   input  wire logic                 arst_n_i,
   input  wire logic                 cs_n_i,
   input  wire logic                 wr_n_i,
   input  wire logic                 rd_n_i,
   input  wire logic [ACS_BUS_W-1:0] data_i,
   input  wire logic                 bipolar_i,
   input  wire logic [ACS_RES_W-2:0] sar_magnitude_i,
   input  wire logic                 sar_negative_i,
   output logic      [ACS_BUS_W-1:0] data_o,
   output logic                      data_oe_o,
   output logic                      done_n_o,
   output logic                      sample_o,
   output logic                      calibrating_o,
   output logic                      calibrated_o
);

   // Two-stage synchronisers for the bus strobes and data pins
   logic [2:0]           strb_meta_reg;
   logic [2:0]           strb_sync_reg;
   logic [2:0]           strb_prev_reg;
   logic [ACS_BUS_W-1:0] data_meta_reg;
   logic [ACS_BUS_W-1:0] data_sync_reg;
   logic                 pol_meta_reg;
   logic                 pol_sync_reg;
   logic                 cs_n;
   logic                 wr_n;
   logic                 rd_n;
   logic                 wr_sel;
   logic                 wr_sel_prev;
   logic                 rd_sel;
   logic                 rd_sel_prev;
   logic                 cmd_strobe;
   logic                 rd_fall;
   logic                 wr_fall;
   logic                 wr_low_fall;

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         strb_meta_reg <= 3'h7;
         strb_sync_reg <= 3'h7;
         strb_prev_reg <= 3'h7;
         data_meta_reg <= ACS_BUS_IDLE;
         data_sync_reg <= ACS_BUS_IDLE;
         pol_meta_reg  <= 1'b0;
         pol_sync_reg  <= 1'b0;
      end
      else
      begin
         strb_meta_reg <= {rd_n_i, wr_n_i, cs_n_i};
         strb_sync_reg <= strb_meta_reg;
         strb_prev_reg <= strb_sync_reg;
         data_meta_reg <= data_i;
         data_sync_reg <= data_meta_reg;
         pol_meta_reg  <= bipolar_i;
         pol_sync_reg  <= pol_meta_reg;
      end
   end

   assign cs_n        = strb_sync_reg[0];
   assign wr_n        = strb_sync_reg[1];
   assign rd_n        = strb_sync_reg[2];
   assign wr_sel      = !cs_n && !wr_n;
   assign wr_sel_prev = !strb_prev_reg[0] && !strb_prev_reg[1];
   assign rd_sel      = !cs_n && !rd_n;
   assign rd_sel_prev = !strb_prev_reg[0] && !strb_prev_reg[2];
   // End of a write cycle: whichever of chip select or write rises first
   assign cmd_strobe  = wr_sel_prev && !wr_sel;
   assign rd_fall     = rd_sel && !rd_sel_prev;
   assign wr_fall     = wr_sel && !wr_sel_prev;
   assign wr_low_fall = !wr_n && strb_prev_reg[1];

   // Command decode: bit five high with bits four and zero low converts; bit five and bits three to zero low calibrates
   function automatic logic [1:0] acs_decode(input logic [ACS_CMD_W-1:0] cmd);
      logic [1:0] kind;
      kind = 2'b00;
      if (cmd[ACS_CMD_SEL_BIT] && !cmd[ACS_CMD_Q_BIT] && !cmd[ACS_CMD_LSB_BIT])
         kind = 2'b01;
      else if (!cmd[ACS_CMD_SEL_BIT] && cmd[ACS_CMD_Q_BIT-1:ACS_CMD_LSB_BIT] == 4'h0)
         kind = 2'b10;
      return kind;
   endfunction

   logic [1:0]           cmd_kind;
   assign cmd_kind = cmd_strobe ? acs_decode(data_sync_reg[ACS_CMD_W-1:0]) : 2'b00;

   // Sequencer state
   acs_state_t           state_reg;
   acs_state_t           state_next;
   logic [ACS_CNT_W-1:0] cnt_reg;
   logic [ACS_CNT_W-1:0] cnt_next;
   logic                 done_n_reg;
   logic                 done_n_next;
   logic                 hold_reg;
   logic                 hold_next;
   logic                 fresh_reg;
   logic                 fresh_next;
   logic                 cal_ok_reg;
   logic                 cal_ok_next;
   logic [ACS_RES_W-1:0] result_reg;
   logic [ACS_RES_W-1:0] result_next;
   logic                 conv_end;
   logic                 cal_end;

   // Count holds the number of the cycle now in progress, starting at one
   assign conv_end = (state_reg == ACS_CONV) && (cnt_reg == ACS_CNT_W'(CONV_CYCLES));
   assign cal_end  = (state_reg == ACS_CAL) && (cnt_reg == ACS_CNT_W'(CAL_CYCLES));

   always_comb
   begin
      state_next  = state_reg;
      cnt_next    = cnt_reg;
      done_n_next = done_n_reg;
      hold_next   = hold_reg;
      fresh_next  = 1'b0;
      cal_ok_next = cal_ok_reg;
      result_next = result_reg;
      case (state_reg)
         ACS_CONV:
         begin
            cnt_next = cnt_reg + 1'b1;
            if (conv_end)
            begin
               state_next = ACS_IDLE;
               cnt_next   = '0;
               // Sign bit forced low when unipolar; magnitude zero-extended, negated when bipolar and negative
               if (pol_sync_reg && sar_negative_i)
                  result_next = -{1'b0, sar_magnitude_i};
               else
                  result_next = {1'b0, sar_magnitude_i};
            end
         end
         ACS_CAL:
         begin
            cnt_next = cnt_reg + 1'b1;
            if (cal_end)
            begin
               state_next  = ACS_IDLE;
               cnt_next    = '0;
               cal_ok_next = 1'b1;
            end
         end
         ACS_IDLE:
         begin
            cnt_next = '0;
         end
         default:
         begin
            state_next = ACS_IDLE;
            cnt_next   = '0;
         end
      endcase
      // Done flag: clears on first read select or any write select; else holds
      if (hold_reg && wr_low_fall)
      begin
         done_n_next = 1'b1;
         hold_next   = 1'b0;
      end
      // Read select landing in the cycle done falls may miss the result, so wait for write
      else if (fresh_reg && rd_fall && !wr_fall)
         hold_next = 1'b1;
      else if (!done_n_reg && !hold_reg && (rd_fall || wr_fall))
         done_n_next = 1'b1;
      // Commands restart from any state; a new command aborts the current one
      if (cmd_kind == 2'b01)
      begin
         state_next = ACS_CONV;
         cnt_next   = ACS_CNT_W'(1);
      end
      else if (cmd_kind == 2'b10)
      begin
         state_next  = ACS_CAL;
         cnt_next    = ACS_CNT_W'(1);
         cal_ok_next = 1'b0;
      end
      // Completion wins over a clear in the same cycle
      if (conv_end && cmd_kind == 2'b00)
      begin
         done_n_next = 1'b0;
         hold_next   = 1'b0;
         fresh_next  = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_reg  <= ACS_IDLE;
         cnt_reg    <= '0;
         done_n_reg <= 1'b1;
         hold_reg   <= 1'b0;
         fresh_reg  <= 1'b0;
         cal_ok_reg <= 1'b0;
         result_reg <= '0;
      end
      else
      begin
         state_reg  <= state_next;
         cnt_reg    <= cnt_next;
         done_n_reg <= done_n_next;
         hold_reg   <= hold_next;
         fresh_reg  <= fresh_next;
         cal_ok_reg <= cal_ok_next;
         result_reg <= result_next;
      end
   end

   // Output bus: enable is the read select from the synchronised strobes, so it lags the pins; data is registered
   assign data_o        = {{(ACS_BUS_W-ACS_RES_W){result_reg[ACS_RES_W-1]}}, result_reg};
   assign data_oe_o     = rd_sel;
   assign done_n_o      = done_n_reg;
   assign sample_o      = (state_reg == ACS_CONV)
                          && (cnt_reg >= ACS_CNT_W'(ACS_SAMPLE_FIRST))
                          && (cnt_reg <= ACS_CNT_W'(ACS_SAMPLE_LAST));
   assign calibrating_o = (state_reg == ACS_CAL);
   assign calibrated_o  = cal_ok_reg;

endmodule // acs_sequencer

/* sim/acs_sequencer_checker.sv */
// Port assertions for the sequencer
`timescale 1ns/1ps
module acs_sequencer_checker
   import acs_pkg::*;
(
   input wire logic                 core_clk_i,
   input wire logic                 arst_n_i,
   input wire logic                 cs_n_i,
   input wire logic                 rd_n_i,
   input wire logic                 bipolar_i,
   input wire logic [ACS_BUS_W-1:0] data_o,
   input wire logic                 data_oe_o,
   input wire logic                 done_n_o,
   input wire logic                 sample_o,
   input wire logic                 calibrating_o,
   input wire logic                 calibrated_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   property p_win; $rose(sample_o) |-> sample_o[*8] ##1 !sample_o; endproperty
   a_win: assert property (p_win) else $error("sample window length wrong");
   // Exact spacing; an abort after sampling would break it, so the bench avoids that
   property p_end; $fell(sample_o) |-> ##14 $fell(done_n_o); endproperty
   a_end: assert property (p_end) else $error("done not at cycle 24");
   property p_hold;
      (!done_n_o && cs_n_i && $past(cs_n_i) && $past(cs_n_i, 2)) |=> !done_n_o;
   endproperty
   a_hold: assert property (p_hold) else $error("done rose without clear");
   property p_oe; (!cs_n_i && !rd_n_i)[*3] |-> data_oe_o; endproperty
   a_oe: assert property (p_oe) else $error("bus not driven on read");
   property p_oe_off; cs_n_i[*3] |-> !data_oe_o; endproperty
   a_oe_off: assert property (p_oe_off) else $error("bus driven unselected");
   property p_ext; data_oe_o |-> data_o[15:13] == {3{data_o[12]}}; endproperty
   a_ext: assert property (p_ext) else $error("sign not extended");
   property p_uni;
      ($fell(done_n_o) && !bipolar_i && !$past(bipolar_i, 4)) |-> !data_o[12];
   endproperty
   a_uni: assert property (p_uni) else $error("unipolar sign set");
   property p_cal; $fell(calibrating_o) |-> calibrated_o; endproperty
   a_cal: assert property (p_cal) else $error("calibration not flagged");
   c_done: cover property ($fell(done_n_o));
   c_cal: cover property ($fell(calibrating_o));
   c_read: cover property ($rose(data_oe_o));
endmodule // acs_sequencer_checker

bind acs_sequencer acs_sequencer_checker acs_sequencer_checker_inst (.core_clk_i(core_clk_i),
   .arst_n_i(arst_n_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .bipolar_i(bipolar_i),
   .data_o(data_o), .data_oe_o(data_oe_o), .done_n_o(done_n_o), .sample_o(sample_o),
   .calibrating_o(calibrating_o), .calibrated_o(calibrated_o));

/* sim/acs_host_model.sv */
// Host processor model on the parallel bus
`timescale 1ns/1ps
module acs_host_model
   import acs_pkg::*;
(
   input  wire logic                 core_clk_i,
   output logic                      cs_n_o,
   output logic                      wr_n_o,
   output logic                      rd_n_o,
   output logic      [ACS_BUS_W-1:0] data_o
);
   int idle_cnt = 0;
   initial
   begin
      cs_n_o = 1'b1;
      wr_n_o = 1'b1;
      rd_n_o = 1'b1;
      data_o = ACS_BUS_IDLE;
   end
   // Released bus shows the inverse so a stale word cannot pass by luck
   always @(negedge core_clk_i)
   begin
      if (cs_n_o) idle_cnt++;
      if (idle_cnt == 4) data_o = ~data_o;
   end
   task automatic write(input logic [ACS_BUS_W-1:0] w);
      @(negedge core_clk_i);
      cs_n_o = 1'b0;
      wr_n_o = 1'b0;
      data_o = w;
      idle_cnt = 0;
      @(negedge core_clk_i);
      wr_n_o = 1'b1;
      cs_n_o = 1'b1;
   endtask
   task automatic read_start();
      @(negedge core_clk_i);
      cs_n_o = 1'b0;
      rd_n_o = 1'b0;
   endtask
   task automatic read_end();
      @(negedge core_clk_i);
      rd_n_o = 1'b1;
      cs_n_o = 1'b1;
   endtask
endmodule // acs_host_model

/* sim/acs_sequencer_bench.sv */
// Scenario testbench for the sequencer
`timescale 1ns/1ps
module acs_sequencer_bench;
   import acs_pkg::*;
   logic clk, arst_n, cs_n, wr_n, rd_n, bip, neg, oe, done_n, smp, cal_run, cal_ok;
   logic [15:0] bus, res;
   logic [11:0] mag;
   int n_fail = 0, n_checks = 0;
   acs_host_model acs_host_model_inst (.core_clk_i(clk), .cs_n_o(cs_n), .wr_n_o(wr_n),
      .rd_n_o(rd_n), .data_o(bus));
   acs_sequencer #(.CAL_CYCLES(30)) acs_sequencer_inst (.core_clk_i(clk), .arst_n_i(arst_n),
      .cs_n_i(cs_n), .wr_n_i(wr_n), .rd_n_i(rd_n), .data_i(bus), .bipolar_i(bip),
      .sar_magnitude_i(mag), .sar_negative_i(neg), .data_o(res), .data_oe_o(oe),
      .done_n_o(done_n), .sample_o(smp), .calibrating_o(cal_run), .calibrated_o(cal_ok));
   always #5 clk = ~clk;
   task automatic wrap_up();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(logic [15:0] got, logic [15:0] exp, string what);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // Early cycles skipped: an unread earlier result is still low until the write clears it
   task automatic wait_done(output int cyc, output int ns);
      ns = 0;
      for (cyc = 1; cyc <= 400; cyc++)
      begin
         @(negedge clk);
         if (smp === 1'b1) ns++;
         if (cyc > 3 && done_n === 1'b0) return;
      end
      n_fail++;
      $display("unexpected at %0t: done timeout", $time);
      wrap_up();
   endtask
   task automatic conv_len();
      int c, s;
      wait_done(c, s);
      check(16'(c), 16'd27, "conversion length");
      check(16'(s), 16'd8, "sample cycles");
   endtask
   task automatic t_conv(logic b, logic ng, logic [11:0] m, logic [15:0] exp);
      bip = b;
      neg = ng;
      mag = m;
      acs_host_model_inst.write(16'h0020);
      conv_len();
      acs_host_model_inst.read_start();
      repeat (3) @(negedge clk);
      check(res, exp, "result");
      check({15'h0, oe}, 16'h0001, "bus drive");
      check({15'h0, done_n}, 16'h0001, "done clear");
      acs_host_model_inst.read_end();
      $display("conversion test ended");
   endtask
   task automatic t_abort();
      acs_host_model_inst.write(16'h0020);
      acs_host_model_inst.write(16'h0020);
      conv_len();
      $display("abort test ended");
   endtask
   task automatic t_race();
      acs_host_model_inst.write(16'h0020);
      repeat (24) @(negedge clk);
      acs_host_model_inst.read_start();
      repeat (5) @(negedge clk);
      check({15'h0, done_n}, 16'h0000, "done kept on race");
      acs_host_model_inst.read_end();
      acs_host_model_inst.write(16'h003F);
      repeat (3) @(negedge clk);
      check({15'h0, done_n}, 16'h0001, "done cleared by write");
      $display("race test ended");
   endtask
   task automatic t_cal();
      int c;
      c = 0;
      repeat (20) @(negedge clk);
      acs_host_model_inst.write(16'h0000);
      for (int i = 0; i < 100 && cal_ok !== 1'b1; i++)
      begin
         @(negedge clk);
         if (cal_run === 1'b1) c++;
      end
      if (cal_ok !== 1'b1)
      begin
         n_fail++;
         $display("unexpected at %0t: calibration timeout", $time);
         wrap_up();
      end
      check(16'(c), 16'd30, "calibration length");
      check({15'h0, cal_ok}, 16'h0001, "calibrated");
      $display("calibration test ended");
   endtask
   initial
   begin
      clk = 1'b0;
      arst_n = 1'b0;
      bip = 1'b0;
      neg = 1'b0;
      mag = 12'h000;
      repeat (3) @(negedge clk);
      arst_n = 1'b1;
      check({14'h0, cal_ok, cal_run}, 16'h0000, "no calibration at power-up");
      check({15'h0, done_n}, 16'h0001, "done idle");
      t_conv(1'b1, 1'b1, 12'h123, 16'hFEDD);
      t_cal();
      t_conv(1'b0, 1'b1, 12'hABC, 16'h0ABC);
      t_abort();
      t_conv(1'b1, 1'b0, 12'h7FF, 16'h07FF);
      t_race();
      wrap_up();
   end
endmodule // acs_sequencer_bench
